// ===== verilog/ebpm_pin_mux.sv
// External bus pin multiplexer: routes the static memory controller or the
// SDRAM controller onto one shared set of pins, all outputs registered.
// Assumes owner selection and controller outputs are synchronous to sys_clk_in.
`timescale 1ns/100ps
module ebpm_pin_mux (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Controller side
   input wire ebpm_pkg::ebpm_owner_t owner_in,
   input wire ebpm_pkg::ebpm_smc_t smc_in,
   input wire ebpm_pkg::ebpm_sdr_t sdr_in,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] rdata_out,
   output logic wait_req_out,
   // Shared address and data pins
   output logic [ebpm_pkg::EBPM_ADDR_W-1:0] addr_out,
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] data_in,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] data_out,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] data_oe_out,
   input wire logic ext_wait_n_in,
   // Static strobes and shared card or flash functions
   output logic [ebpm_pkg::EBPM_CS_W-1:0] chip_select_n_out,
   output logic read_strobe_n_out,
   output logic [ebpm_pkg::EBPM_WR_W-1:0] byte_write_strobe_n_out,
   output logic [ebpm_pkg::EBPM_CARD_W-1:0] card_chip_enable_n_out,
   // SDRAM dedicated pins
   output logic sdram_addr_ten_out,
   output logic [ebpm_pkg::EBPM_BANK_W-1:0] bank_select_out,
   output logic sdram_write_n_out,
   output logic row_strobe_n_out,
   output logic col_strobe_n_out,
   output logic sdram_clk_en_out
);
   import ebpm_pkg::*;

   logic [EBPM_ADDR_W-1:0] addr_r, addr_nxt;
   logic [EBPM_CS_W-1:0] cs_r, cs_nxt;
   logic rd_r, rd_nxt;
   logic [EBPM_WR_W-1:0] wr_r, wr_nxt;
   logic [EBPM_CARD_W-1:0] ce_r, ce_nxt;
   logic a10_r, a10_nxt;
   logic [EBPM_BANK_W-1:0] bank_r, bank_nxt;
   logic sdram_write_n_r, sdram_write_n_nxt;
   logic ras_r, ras_nxt;
   logic cas_r, cas_nxt;
   logic cke_r, cke_nxt;
   logic wait_r, wait_nxt;
   logic sdr_own;
   logic [EBPM_DATA_W-1:0] wdata_sel;
   logic wdata_oe_sel;

   // Combine two active-low functions that share one pin
   function automatic logic share_low(input logic a_n, input logic b_n);
      share_low = a_n & b_n;
   endfunction

   // Pick a strobe from its owner, resting high while the other side owns the bus
   function automatic logic own_strobe(input logic owned, input logic strobe_n);
      own_strobe = owned ? strobe_n : EBPM_STROBE_IDLE;
   endfunction

   assign sdr_own = (owner_in == EBPM_OWN_SDR);

   always_comb begin
      addr_nxt = EBPM_ADDR_IDLE;
      cs_nxt = EBPM_CS_IDLE;
      rd_nxt = EBPM_STROBE_IDLE;
      wr_nxt = EBPM_WR_IDLE;
      ce_nxt = EBPM_CARD_IDLE;
      if (sdr_own) begin
         addr_nxt[11:2] = sdr_in.addr[9:0];
         addr_nxt[14:13] = sdr_in.addr[12:11];
         // Address bits 0, 1, 12 and 25 to 15 stay at rest
         cs_nxt[EBPM_CS_SDRAM] = sdr_in.sdram_select_n;
         wr_nxt[EBPM_WR_UPPER] = sdr_in.byte_mask_n[EBPM_WR_UPPER];
         wr_nxt[EBPM_WR_LANE3] = sdr_in.byte_mask_n[EBPM_WR_LANE3];
      end else begin
         addr_nxt = smc_in.addr;
         cs_nxt = smc_in.chip_select_n;
         cs_nxt[EBPM_CS_NFLASH] = share_low(smc_in.chip_select_n[EBPM_CS_NFLASH],
            smc_in.nflash_select_n);
         cs_nxt[EBPM_CS_NFLASH_OE] = share_low(smc_in.chip_select_n[EBPM_CS_NFLASH_OE],
            smc_in.nflash_output_enable_n);
         cs_nxt[EBPM_CS_NFLASH_WE] = share_low(smc_in.chip_select_n[EBPM_CS_NFLASH_WE],
            smc_in.nflash_write_enable_n);
         cs_nxt[EBPM_CS_CARD0] = share_low(smc_in.chip_select_n[EBPM_CS_CARD0],
            smc_in.card_select_n[0]);
         cs_nxt[EBPM_CS_CARD1] = share_low(smc_in.chip_select_n[EBPM_CS_CARD1],
            smc_in.card_select_n[1]);
         rd_nxt = share_low(smc_in.read_strobe_n, smc_in.card_output_enable_n);
         wr_nxt = smc_in.byte_write_strobe_n;
         wr_nxt[EBPM_WR_LOWER] = share_low(smc_in.byte_write_strobe_n[EBPM_WR_LOWER],
            smc_in.card_write_enable_n);
         wr_nxt[EBPM_WR_UPPER] = share_low(smc_in.byte_write_strobe_n[EBPM_WR_UPPER],
            smc_in.card_io_read_n);
         wr_nxt[EBPM_WR_LANE3] = share_low(smc_in.byte_write_strobe_n[EBPM_WR_LANE3],
            smc_in.card_io_write_n);
         ce_nxt = smc_in.card_chip_enable_n;
         // Card buffer direction takes the top address line only while a card
         // slot is selected, so plain static accesses keep address bit 25
         if (!(&smc_in.card_select_n)) begin
            addr_nxt[EBPM_ADDR_W-1] = smc_in.card_read_not_write;
         end
      end
      if (!rst_n_in) begin
         addr_nxt = EBPM_ADDR_IDLE;
         cs_nxt = EBPM_CS_IDLE;
         rd_nxt = EBPM_STROBE_IDLE;
         wr_nxt = EBPM_WR_IDLE;
         ce_nxt = EBPM_CARD_IDLE;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      addr_r <= addr_nxt;
      cs_r <= cs_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      ce_r <= ce_nxt;
   end

   // SDRAM dedicated pins; clock enable and bank stay with the SDRAM side so
   // that a self-refresh state survives while the static side owns the bus
   always_comb begin
      a10_nxt = sdr_in.addr[10];
      bank_nxt = sdr_in.bank_select;
      sdram_write_n_nxt = own_strobe(sdr_own, sdr_in.sdram_write_n);
      ras_nxt = own_strobe(sdr_own, sdr_in.row_strobe_n);
      cas_nxt = own_strobe(sdr_own, sdr_in.col_strobe_n);
      cke_nxt = sdr_in.sdram_clk_en;
      wait_nxt = ~ext_wait_n_in & ~sdr_own;
      if (!rst_n_in) begin
         a10_nxt = 1'b0;
         bank_nxt = EBPM_BANK_IDLE;
         sdram_write_n_nxt = EBPM_STROBE_IDLE;
         ras_nxt = EBPM_STROBE_IDLE;
         cas_nxt = EBPM_STROBE_IDLE;
         cke_nxt = EBPM_CKE_IDLE;
         wait_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      a10_r <= a10_nxt;
      bank_r <= bank_nxt;
      sdram_write_n_r <= sdram_write_n_nxt;
      ras_r <= ras_nxt;
      cas_r <= cas_nxt;
      cke_r <= cke_nxt;
      wait_r <= wait_nxt;
   end

   assign wdata_sel = sdr_own ? sdr_in.wdata : smc_in.wdata;
   assign wdata_oe_sel = sdr_own ? sdr_in.wdata_oe : smc_in.wdata_oe;

   // 32 two-way data lines
   ebpm_data_pad u_data_pad (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .wdata_in(wdata_sel),
      .wdata_oe_in(wdata_oe_sel),
      .rdata_out(rdata_out),
      .pin_in(data_in),
      .pin_out(data_out),
      .pin_oe_out(data_oe_out)
   );

   assign addr_out = addr_r;
   assign chip_select_n_out = cs_r;
   assign read_strobe_n_out = rd_r;
   assign byte_write_strobe_n_out = wr_r;
   assign card_chip_enable_n_out = ce_r;
   assign sdram_addr_ten_out = a10_r;
   assign bank_select_out = bank_r;
   assign sdram_write_n_out = sdram_write_n_r;
   assign row_strobe_n_out = ras_r;
   assign col_strobe_n_out = cas_r;
   assign sdram_clk_en_out = cke_r;
   assign wait_req_out = wait_r;

   sequence sdr_cycle_s;
      (rst_n_in && owner_in == EBPM_OWN_SDR) ##1 rst_n_in;
   endsequence

   sequence smc_cycle_s;
      (rst_n_in && owner_in == EBPM_OWN_SMC) ##1 rst_n_in;
   endsequence

   sdr_addr_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sdr_cycle_s |-> addr_out[11:2] == $past(sdr_in.addr[9:0])
         && addr_out[14:13] == $past(sdr_in.addr[12:11]))
      else $error("SDRAM address not on pins 14 to 2");

   sdr_unused_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sdr_cycle_s |-> addr_out[25:15] == 11'h000 && addr_out[12] == 1'b0
         && addr_out[1:0] == 2'h0)
      else $error("SDRAM owner drives a static-only address pin");

   smc_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      smc_cycle_s |-> addr_out[24:0] == $past(smc_in.addr[24:0]))
      else $error("static address not on pins 24 to 0");

   card_dir_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      smc_cycle_s |-> addr_out[25] == ($past(&smc_in.card_select_n) ?
         $past(smc_in.addr[25]) : $past(smc_in.card_read_not_write)))
      else $error("top address pin carries neither bit 25 nor card direction");

   addr_ten_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $past(rst_n_in) |-> sdram_addr_ten_out == $past(sdr_in.addr[10]))
      else $error("address ten pin does not carry SDRAM bit 10");

   upper_byte_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sdr_cycle_s |-> byte_write_strobe_n_out[1] == $past(sdr_in.byte_mask_n[1]))
      else $error("upper byte pin does not carry SDRAM mask 1");

   sdr_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      smc_cycle_s |-> sdram_write_n_out && row_strobe_n_out && col_strobe_n_out)
      else $error("SDRAM strobe active while static side owns the bus");

   smc_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sdr_cycle_s |-> read_strobe_n_out && byte_write_strobe_n_out[0]
         && card_chip_enable_n_out == 2'h3 && chip_select_n_out[0])
      else $error("static strobe active while SDRAM owns the bus");

   wait_req_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      smc_cycle_s |-> wait_req_out == !$past(ext_wait_n_in))
      else $error("wait request does not follow the wait input");

   sdr_select_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sdr_cycle_s |-> chip_select_n_out[1] == $past(sdr_in.sdram_select_n)
         && sdram_clk_en_out == $past(sdr_in.sdram_clk_en))
      else $error("SDRAM select or clock enable misrouted");

endmodule

// ===== verilog/ebpm_pkg.sv
// Shared constants and carrier types for the external bus pin multiplexer.
// Assumes both memory controllers run on the same system bus clock as the mux.
package ebpm_pkg;

   localparam int EBPM_ADDR_W = 26;
   localparam int EBPM_DATA_W = 32;
   localparam int EBPM_CS_W = 8;
   localparam int EBPM_WR_W = 4;
   localparam int EBPM_SDR_ADDR_W = 13;
   localparam int EBPM_BANK_W = 2;
   localparam int EBPM_CARD_W = 2;

   // Chip select lines shared with dedicated strobes
   localparam int EBPM_CS_SDRAM = 1;
   localparam int EBPM_CS_NFLASH = 3;
   localparam int EBPM_CS_CARD0 = 4;
   localparam int EBPM_CS_CARD1 = 5;
   localparam int EBPM_CS_NFLASH_OE = 6;
   localparam int EBPM_CS_NFLASH_WE = 7;

   // Byte write strobe lanes
   localparam int EBPM_WR_LOWER = 0;
   localparam int EBPM_WR_UPPER = 1;
   localparam int EBPM_WR_LANE3 = 3;

   // Reset and idle values of the pins
   localparam logic [EBPM_ADDR_W-1:0] EBPM_ADDR_IDLE = 26'h000_0000;
   localparam logic [EBPM_CS_W-1:0] EBPM_CS_IDLE = 8'hFF;
   localparam logic [EBPM_WR_W-1:0] EBPM_WR_IDLE = 4'hF;
   localparam logic [EBPM_CARD_W-1:0] EBPM_CARD_IDLE = 2'h3;
   localparam logic [EBPM_BANK_W-1:0] EBPM_BANK_IDLE = 2'h0;
   localparam logic [EBPM_DATA_W-1:0] EBPM_DATA_IDLE = 32'h0000_0000;
   localparam logic EBPM_STROBE_IDLE = 1'b1;
   localparam logic EBPM_CKE_IDLE = 1'b0;
   localparam logic EBPM_RNW_IDLE = 1'b1;

   typedef enum logic {
      EBPM_OWN_SMC = 1'b0,
      EBPM_OWN_SDR = 1'b1
   } ebpm_owner_t;

   // Static memory controller side, including card and flash glue strobes
   typedef struct packed {
      logic [EBPM_ADDR_W-1:0] addr;
      logic [EBPM_CS_W-1:0] chip_select_n;
      logic read_strobe_n;
      logic [EBPM_WR_W-1:0] byte_write_strobe_n;
      logic nflash_select_n;
      logic nflash_output_enable_n;
      logic nflash_write_enable_n;
      logic card_output_enable_n;
      logic card_write_enable_n;
      logic card_io_read_n;
      logic card_io_write_n;
      logic [EBPM_CARD_W-1:0] card_chip_enable_n;
      logic [EBPM_CARD_W-1:0] card_select_n;
      logic card_read_not_write;
      logic [EBPM_DATA_W-1:0] wdata;
      logic wdata_oe;
   } ebpm_smc_t;

   // SDRAM controller side
   typedef struct packed {
      logic [EBPM_SDR_ADDR_W-1:0] addr;
      logic [EBPM_BANK_W-1:0] bank_select;
      logic sdram_select_n;
      logic sdram_write_n;
      logic row_strobe_n;
      logic col_strobe_n;
      logic sdram_clk_en;
      logic [EBPM_WR_W-1:0] byte_mask_n;
      logic [EBPM_DATA_W-1:0] wdata;
      logic wdata_oe;
   } ebpm_sdr_t;

endpackage

// ===== verilog/ebpm_data_pad.sv
// Registered data bus pad stage: drive value, enable and captured input.
// Assumes the pad ring resolves the wire level from the enable.
`timescale 1ns/100ps
module ebpm_data_pad (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Core side
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] wdata_in,
   input wire logic wdata_oe_in,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] rdata_out,
   // Pin side
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] pin_in,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] pin_out,
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] pin_oe_out
);
   import ebpm_pkg::*;

   logic [EBPM_DATA_W-1:0] dout_r, dout_nxt;
   logic [EBPM_DATA_W-1:0] oe_r, oe_nxt;
   logic [EBPM_DATA_W-1:0] din_r, din_nxt;

   // Every line keeps its own bit position in both directions
   always_comb begin
      dout_nxt = wdata_in;
      oe_nxt = {EBPM_DATA_W{wdata_oe_in}};
      din_nxt = pin_in;
      if (!rst_n_in) begin
         dout_nxt = EBPM_DATA_IDLE;
         oe_nxt = EBPM_DATA_IDLE;
         din_nxt = EBPM_DATA_IDLE;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      din_r <= din_nxt;
   end

   assign pin_out = dout_r;
   assign pin_oe_out = oe_r;
   assign rdata_out = din_r;

   data_drive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $past(rst_n_in) |-> pin_out == $past(wdata_in)
         && pin_oe_out == {EBPM_DATA_W{$past(wdata_oe_in)}})
      else $error("data pin drive does not follow the active controller");

endmodule

// ===== verif/ebpm_ext_model.sv
// Far-side model: external memories on the shared data pins and the wait line.
// Assumes the bench sets the read word and whether an access is stretched.
`timescale 1ns/100ps
module ebpm_ext_model (
   // Clock
   input wire logic sys_clk_in,
   // Pins from the mux
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] data_out_in,
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] data_oe_in,
   input wire logic read_strobe_n_in,
   input wire logic col_strobe_n_in,
   input wire logic sdram_write_n_in,
   // Bench control
   input wire logic [ebpm_pkg::EBPM_DATA_W-1:0] rd_word_in,
   input wire logic stretch_in,
   // Pins to the mux
   output logic [ebpm_pkg::EBPM_DATA_W-1:0] data_in_out,
   output logic ext_wait_n_out
);
   import ebpm_pkg::*;
   logic [EBPM_DATA_W-1:0] last_r = 32'h0000_0000;
   logic mem_drive;
   assign mem_drive = !read_strobe_n_in || (!col_strobe_n_in && sdram_write_n_in);
   // Released bits show the read word while a memory drives, else the inverse of their last level, never a held value
   always_comb begin
      for (int i = 0; i < EBPM_DATA_W; i++) begin
         data_in_out[i] = data_oe_in[i] ? data_out_in[i] :
                          (mem_drive ? rd_word_in[i] : ~last_r[i]);
      end
   end
   always_ff @(posedge sys_clk_in) begin
      last_r <= data_in_out;
   end
   // Stretch request is a low level
   assign ext_wait_n_out = !stretch_in;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the external bus pin multiplexer.
// Assumes the far-side model resolves the data wire and the wait line.
`timescale 1ns/100ps
module testbench;
   import ebpm_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   ebpm_owner_t owner;
   ebpm_smc_t static_mem_controller;
   ebpm_sdr_t sdr;
   logic [31:0] rdata, data_in, data_out, data_oe, rd_word;
   logic [25:0] addr;
   logic [7:0] cs_n;
   logic [3:0] wr_n;
   logic [1:0] ce_n, bank;
   logic wait_req, ext_wait_n, rd_n, a10, sd_we_n, ras_n, cas_n, cke, stretch;
   int num_errors = 0;
   int n_compared = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   ebpm_pin_mux DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .owner_in(owner),
      .smc_in(static_mem_controller), .sdr_in(sdr), .rdata_out(rdata), .wait_req_out(wait_req),
      .addr_out(addr), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe),
      .ext_wait_n_in(ext_wait_n), .chip_select_n_out(cs_n), .read_strobe_n_out(rd_n),
      .byte_write_strobe_n_out(wr_n), .card_chip_enable_n_out(ce_n),
      .sdram_addr_ten_out(a10), .bank_select_out(bank), .sdram_write_n_out(sd_we_n),
      .row_strobe_n_out(ras_n), .col_strobe_n_out(cas_n), .sdram_clk_en_out(cke));
   ebpm_ext_model ext (.sys_clk_in(sys_clk_in), .data_out_in(data_out),
      .data_oe_in(data_oe), .read_strobe_n_in(rd_n), .col_strobe_n_in(cas_n),
      .sdram_write_n_in(sd_we_n), .rd_word_in(rd_word), .stretch_in(stretch),
      .data_in_out(data_in), .ext_wait_n_out(ext_wait_n));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic idle();
      static_mem_controller = '1;
      static_mem_controller.addr = '0;
      static_mem_controller.card_read_not_write = 1'b0;
      static_mem_controller.wdata = '0;
      static_mem_controller.wdata_oe = 1'b0;
      sdr = '1;
      sdr.addr = '0;
      sdr.bank_select = '0;
      sdr.sdram_clk_en = 1'b0;
      sdr.wdata = '0;
      sdr.wdata_oe = 1'b0;
   endtask
   function automatic logic [25:0] sdr_map(input logic [12:0] a);
      return {11'h000, a[12:11], 1'b0, a[9:0], 2'b00};
   endfunction
   task automatic t_reset();
      check(addr, 32'h0, "reset addr");
      check({cs_n, wr_n, ce_n, rd_n, sd_we_n, ras_n, cas_n}, 18'h3_FFFF, "reset strobes");
      check({bank, a10, cke, wait_req}, 32'h0, "reset sdram");
      check(data_oe, 32'h0, "reset oe");
      $display("test reset done");
   endtask
   task automatic t_saddr();
      owner = EBPM_OWN_SMC;
      idle();
      sdr = '0;
      sdr.addr = '1;
      for (int i = 0; i < 26; i++) begin
         static_mem_controller.addr = 26'h1 << i;
         @(negedge sys_clk_in);
         check(addr, 26'h1 << i, "static addr");
      end
      check({cs_n, wr_n, sd_we_n, ras_n, cas_n}, 15'h7FFF, "idle sdram pins");
      check({a10, bank, cke}, 4'h8, "sdram dedicated");
      static_mem_controller.addr = '0;
      static_mem_controller.card_read_not_write = 1'b1;
      static_mem_controller.card_select_n = 2'h2;
      @(negedge sys_clk_in);
      check(addr, 26'h200_0000, "card direction");
      static_mem_controller.card_select_n = 2'h3;
      @(negedge sys_clk_in);
      check(addr, 26'h0, "card released");
      $display("test static address done");
   endtask
   task automatic t_daddr();
      owner = EBPM_OWN_SDR;
      static_mem_controller = '0;
      static_mem_controller.addr = '1;
      sdr = '0;
      sdr.sdram_clk_en = 1'b1;
      sdr.bank_select = 2'h2;
      sdr.byte_mask_n = 4'h5;
      for (int i = 0; i < 13; i++) begin
         sdr.addr = 13'h1 << i;
         @(negedge sys_clk_in);
         check(addr, sdr_map(13'h1 << i), "sdram addr");
         check(a10, i == 10, "address ten");
      end
      check({cs_n, wr_n, ce_n, rd_n}, {8'hFD, 4'h5, 2'h3, 1'b1}, "sdram strobes");
      check({sd_we_n, ras_n, cas_n, cke, bank}, 6'h06, "sdram polarity");
      $display("test sdram address done");
   endtask
   task automatic t_switch();
      idle();
      static_mem_controller.addr = 26'h155_5555;
      sdr.addr = 13'h1ABC;
      sdr.sdram_write_n = 1'b0;
      sdr.row_strobe_n = 1'b0;
      sdr.col_strobe_n = 1'b0;
      for (int k = 0; k < 6; k++) begin
         owner = ebpm_owner_t'(k[0]);
         @(negedge sys_clk_in);
         check(addr, k[0] ? sdr_map(13'h1ABC) : 26'h155_5555, "switch addr");
         check({sd_we_n, ras_n, cas_n}, k[0] ? 3'h0 : 3'h7, "switch strobes");
      end
      $display("test switching done");
   endtask
   task automatic t_strobe();
      logic [14:0] exp [12] = '{{8'h00, 4'hF, 2'h3, 1'b1}, {8'hF7, 4'hF, 2'h3, 1'b1},
         {8'hBF, 4'hF, 2'h3, 1'b1}, {8'h7F, 4'hF, 2'h3, 1'b1}, {8'hCF, 4'hF, 2'h3, 1'b1},
         {8'hFF, 4'hF, 2'h3, 1'b0}, {8'hFF, 4'hF, 2'h3, 1'b0}, {8'hFF, 4'hD, 2'h3, 1'b1},
         {8'hFF, 4'hE, 2'h3, 1'b1}, {8'hFF, 4'hD, 2'h3, 1'b1}, {8'hFF, 4'h7, 2'h3, 1'b1},
         {8'hFF, 4'hF, 2'h1, 1'b1}};
      owner = EBPM_OWN_SMC;
      for (int i = 0; i < 12; i++) begin
         idle();
         case (i)
            0: static_mem_controller.chip_select_n = 8'h00;
            1: static_mem_controller.nflash_select_n = 1'b0;
            2: static_mem_controller.nflash_output_enable_n = 1'b0;
            3: static_mem_controller.nflash_write_enable_n = 1'b0;
            4: static_mem_controller.card_select_n = 2'h0;
            5: static_mem_controller.read_strobe_n = 1'b0;
            6: static_mem_controller.card_output_enable_n = 1'b0;
            7: static_mem_controller.byte_write_strobe_n = 4'hD;
            8: static_mem_controller.card_write_enable_n = 1'b0;
            9: static_mem_controller.card_io_read_n = 1'b0;
            10: static_mem_controller.card_io_write_n = 1'b0;
            default: static_mem_controller.card_chip_enable_n = 2'h1;
         endcase
         @(negedge sys_clk_in);
         check({cs_n, wr_n, ce_n, rd_n}, exp[i], "static strobe");
      end
      $display("test strobes done");
   endtask
   task automatic t_data();
      idle();
      static_mem_controller.wdata = 32'hA5C3_0F96;
      static_mem_controller.wdata_oe = 1'b1;
      sdr.wdata = 32'h5A3C_F069;
      @(negedge sys_clk_in);
      check(data_out, 32'hA5C3_0F96, "static write");
      check(data_oe, 32'hFFFF_FFFF, "static oe");
      owner = EBPM_OWN_SDR;
      sdr.wdata_oe = 1'b1;
      @(negedge sys_clk_in);
      check(data_out, 32'h5A3C_F069, "sdram write");
      sdr.wdata_oe = 1'b0;
      sdr.col_strobe_n = 1'b0;
      rd_word = 32'h1234_5678;
      repeat (2) @(negedge sys_clk_in);
      check(rdata, 32'h1234_5678, "sdram read");
      check(data_oe, 32'h0, "owner oe");
      owner = EBPM_OWN_SMC;
      static_mem_controller.wdata_oe = 1'b0;
      static_mem_controller.read_strobe_n = 1'b0;
      rd_word = 32'h8421_C3E7;
      repeat (2) @(negedge sys_clk_in);
      check(rdata, 32'h8421_C3E7, "static read");
      $display("test data done");
   endtask
   task automatic t_wait();
      idle();
      stretch = 1'b1;
      @(negedge sys_clk_in);
      check(wait_req, 1'b1, "wait raised");
      owner = EBPM_OWN_SDR;
      @(negedge sys_clk_in);
      check(wait_req, 1'b0, "wait masked");
      owner = EBPM_OWN_SMC;
      stretch = 1'b0;
      @(negedge sys_clk_in);
      check(wait_req, 1'b0, "wait dropped");
      $display("test wait done");
   endtask
   task automatic t_midrst();
      owner = EBPM_OWN_SDR;
      idle();
      sdr = '0;
      sdr.addr = 13'h1ABC;
      sdr.sdram_clk_en = 1'b1;
      sdr.bank_select = 2'h3;
      sdr.wdata = 32'hC3A5_5A3C;
      sdr.wdata_oe = 1'b1;
      @(negedge sys_clk_in);
      rst_n_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      check({addr, bank, a10, cke}, 30'h0, "mid reset addr");
      check({cs_n, wr_n, ce_n, rd_n, sd_we_n, ras_n, cas_n}, 18'h3_FFFF, "mid reset strobes");
      check(data_oe | data_out, 32'h0, "mid reset data");
      rst_n_in = 1'b1;
      @(negedge sys_clk_in);
      check(addr, sdr_map(13'h1ABC), "after reset addr");
      check({cs_n[1], sd_we_n, ras_n, cas_n, cke, bank, a10}, 8'h0E, "after reset sdram");
      check(data_out, 32'hC3A5_5A3C, "after reset data");
      $display("test mid-run reset done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      owner = EBPM_OWN_SMC;
      idle();
      static_mem_controller.addr = 26'h3FF_FFFF;
      rd_word = 32'h0000_0000;
      stretch = 1'b0;
      repeat (6) @(negedge sys_clk_in);
      t_reset();
      rst_n_in = 1'b1;
      t_saddr();
      t_daddr();
      t_switch();
      t_strobe();
      t_data();
      t_wait();
      t_midrst();
      complete_run();
   end
endmodule
